// >>> hdl/ftw_pkg.sv
// ****************************************************************
// factory trim word store: shared constants and carriers
// ****************************************************************
package ftw_pkg;

   localparam int WORD_W = 14;
   localparam int ADDR_W = 14;

   // ****************************************************************
   // calibration area in program memory space
   // ****************************************************************
   localparam logic [13:0] CAL_FIRST_ADDR = 14'h2080;
   localparam logic [13:0] CAL_LAST_ADDR = 14'h208f;
   localparam logic [13:0] THERMAL_AMP_ADDR = 14'h2083;
   localparam logic [13:0] TEMP_REF_ADDR = 14'h2084;
   localparam logic [13:0] COARSE_OFS_ADDR = 14'h2085;
   localparam logic [13:0] FINE_OFS_ADDR = 14'h2086;
   localparam logic [13:0] ZERO_WORD = 14'h0000;

   // ****************************************************************
   // field layout
   // ****************************************************************
   localparam int OVT_MSB = 11;
   localparam int OVT_LSB = 8;
   localparam int OVT_W = 4;
   localparam int AMP_MSB = 3;
   localparam int AMP_LSB = 0;
   localparam int AMP_W = 4;
   localparam int TSR_MSB = 9;
   localparam int TSR_LSB = 0;
   localparam int TSR_W = 10;
   localparam int OFS_MSB = 7;
   localparam int OFS_LSB = 0;
   localparam int OFS_W = 8;

   // ****************************************************************
   // weight of one offset count
   // ****************************************************************
   localparam int COARSE_STEP_MV = 16;
   // fine step is 0.7 mV, carried in microvolts to stay integral
   localparam int FINE_STEP_UV = 700;
   localparam int COARSE_CORR_W = 13;
   localparam int FINE_CORR_W = 18;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [13:0] addr;
      logic [13:0] wdata;
   } ftw_req_t;

   typedef struct packed {
      logic valid;
      logic hit;
      logic [13:0] data;
   } ftw_rsp_t;

endpackage : ftw_pkg

// >>> hdl/ftw_word_pack.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// places one field in a calibration word, all other bits zero
// ****************************************************************
module ftw_word_pack #(
   parameter int MSB = 3,
   parameter int LSB = 0
) (
   input wire logic [MSB-LSB:0] i_field,
   output logic [13:0] o_word
);

   genvar b;
   generate
      for (b = 0; b < ftw_pkg::WORD_W; b = b + 1) begin : g_bit
         if (b >= LSB && b <= MSB) begin : g_in
            assign o_word[b] = i_field[b-LSB];
         end else begin : g_out
            assign o_word[b] = 1'b0;
         end
      end
   endgenerate

endmodule : ftw_word_pack
`default_nettype wire

// >>> hdl/ftw_offset_scale.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// two's complement offset count to signed correction
// ****************************************************************
module ftw_offset_scale #(
   parameter int STEP = 16,
   parameter int OUT_W = 13
) (
   input wire logic [7:0] i_count,
   output logic signed [OUT_W-1:0] o_corr,
   output logic o_neg
);

   localparam logic signed [OUT_W-1:0] STEP_S = OUT_W'(STEP);

   logic signed [OUT_W-1:0] count_ext;

   // top bit of the count is the sign
   assign o_neg = i_count[ftw_pkg::OFS_MSB];
   assign count_ext = OUT_W'($signed(i_count));
   assign o_corr = count_ext * STEP_S;

endmodule : ftw_offset_scale
`default_nettype wire

// >>> hdl/ftw_trim_store.sv
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - The thermal and amp trim word carries the overtemperature threshold trim in bits 11..8.
// - The thermal and amp trim word carries the error-amplifier offset trim in bits 3..0.
// - Bits 13..12 and 7..4 of the thermal and amp trim word always read zero.
// - The word at 2084h holds the 10-bit temperature sensor reading at +30 C in bits 9..0.
// - Bits 13..10 of the temperature reference word always read zero.
// - The word at 2085h holds a signed coarse offset count in bits 7..0.
// - One coarse count weighs 16 mV and a set bit 7 means negative.
// - The word at 2086h holds a signed fine offset count in bits 7..0.
// - One fine count weighs 0.7 mV and a clear bit 7 means positive.
// - Bits 13..8 of both offset count words always read zero.
// - Locations 2080h..208Fh are read-only and reached through the flash read path.
// - The thermal and amp trim word sits at 2083h.
module ftw_trim_store #(
   parameter logic [3:0] OVT_TRIM = 4'hf,
   parameter logic [3:0] AMP_TRIM = 4'hf,
   parameter logic [9:0] TEMP_REF = 10'h3ff,
   parameter logic [7:0] COARSE_COUNT = 8'hff,
   parameter logic [7:0] FINE_COUNT = 8'hff
) (
   input wire logic I_SYS_CLK,
   input wire logic I_RESET_N,
   input wire ftw_pkg::ftw_req_t I_REQ,
   output var ftw_pkg::ftw_rsp_t O_RSP,
   output logic O_WR_IGNORED,
   output logic O_COARSE_NEG,
   output logic O_FINE_NEG,
   output logic signed [ftw_pkg::COARSE_CORR_W-1:0] O_COARSE_CORR_MV,
   output logic signed [ftw_pkg::FINE_CORR_W-1:0] O_FINE_CORR_UV
);

   // ****************************************************************
   // word images; contents are fixed at manufacture
   // ****************************************************************
   logic [13:0] ovt_word;
   logic [13:0] amp_word;
   logic [13:0] thermal_amp_word;
   logic [13:0] temp_ref_word;
   logic [13:0] coarse_word;
   logic [13:0] fine_word;

   ftw_word_pack #(
      .MSB(ftw_pkg::OVT_MSB),
      .LSB(ftw_pkg::OVT_LSB)
   ) u_pack_ovt (
      .i_field(OVT_TRIM),
      .o_word(ovt_word)
   );

   ftw_word_pack #(
      .MSB(ftw_pkg::AMP_MSB),
      .LSB(ftw_pkg::AMP_LSB)
   ) u_pack_amp (
      .i_field(AMP_TRIM),
      .o_word(amp_word)
   );

   // unused positions are zero in both images, so or-ing keeps them zero
   assign thermal_amp_word = ovt_word | amp_word;

   ftw_word_pack #(
      .MSB(ftw_pkg::TSR_MSB),
      .LSB(ftw_pkg::TSR_LSB)
   ) u_pack_tsr (
      .i_field(TEMP_REF),
      .o_word(temp_ref_word)
   );

   ftw_word_pack #(
      .MSB(ftw_pkg::OFS_MSB),
      .LSB(ftw_pkg::OFS_LSB)
   ) u_pack_coarse (
      .i_field(COARSE_COUNT),
      .o_word(coarse_word)
   );

   ftw_word_pack #(
      .MSB(ftw_pkg::OFS_MSB),
      .LSB(ftw_pkg::OFS_LSB)
   ) u_pack_fine (
      .i_field(FINE_COUNT),
      .o_word(fine_word)
   );

   // ****************************************************************
   // offset counts as signed corrections
   // ****************************************************************
   logic signed [ftw_pkg::COARSE_CORR_W-1:0] coarse_corr;
   logic signed [ftw_pkg::FINE_CORR_W-1:0] fine_corr;
   logic coarse_neg;
   logic fine_neg;

   ftw_offset_scale #(
      .STEP(ftw_pkg::COARSE_STEP_MV),
      .OUT_W(ftw_pkg::COARSE_CORR_W)
   ) u_scale_coarse (
      .i_count(COARSE_COUNT),
      .o_corr(coarse_corr),
      .o_neg(coarse_neg)
   );

   ftw_offset_scale #(
      .STEP(ftw_pkg::FINE_STEP_UV),
      .OUT_W(ftw_pkg::FINE_CORR_W)
   ) u_scale_fine (
      .i_count(FINE_COUNT),
      .o_corr(fine_corr),
      .o_neg(fine_neg)
   );

   // ****************************************************************
   // address decode
   // ****************************************************************
   logic in_area;
   logic is_thermal_amp;
   logic is_temp_ref;
   logic is_coarse;
   logic is_fine;
   logic [13:0] sel_word;

   assign in_area = (I_REQ.addr >= ftw_pkg::CAL_FIRST_ADDR) &&
                    (I_REQ.addr <= ftw_pkg::CAL_LAST_ADDR);
   assign is_thermal_amp = I_REQ.addr == ftw_pkg::THERMAL_AMP_ADDR;
   assign is_temp_ref = I_REQ.addr == ftw_pkg::TEMP_REF_ADDR;
   assign is_coarse = I_REQ.addr == ftw_pkg::COARSE_OFS_ADDR;
   assign is_fine = I_REQ.addr == ftw_pkg::FINE_OFS_ADDR;

   // other area locations belong to words held elsewhere and read zero here
   assign sel_word = is_thermal_amp ? thermal_amp_word :
                     is_temp_ref ? temp_ref_word :
                     is_coarse ? coarse_word :
                     is_fine ? fine_word :
                     ftw_pkg::ZERO_WORD;

   // ****************************************************************
   // read answer and write refusal
   // ****************************************************************
   ftw_pkg::ftw_rsp_t next_rsp;
   logic next_wr_ignored;

   assign next_rsp.valid = I_REQ.rd;
   assign next_rsp.hit = I_REQ.rd && in_area;
   assign next_rsp.data = next_rsp.hit ? sel_word : ftw_pkg::ZERO_WORD;
   // write data is never stored anywhere: the store has no write path
   assign next_wr_ignored = I_REQ.wr && in_area;

   // data stands until the next read so a slow reader can sample late
   always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_RSP <= '0;
      end else if (I_REQ.rd) begin
         O_RSP <= next_rsp;
      end else begin
         O_RSP.valid <= 1'b0;
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_WR_IGNORED <= 1'b0;
      end else begin
         O_WR_IGNORED <= next_wr_ignored;
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_COARSE_CORR_MV <= '0;
         O_FINE_CORR_UV <= '0;
         O_COARSE_NEG <= 1'b0;
         O_FINE_NEG <= 1'b0;
      end else begin
         O_COARSE_CORR_MV <= coarse_corr;
         O_FINE_CORR_UV <= fine_corr;
         O_COARSE_NEG <= coarse_neg;
         O_FINE_NEG <= fine_neg;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   logic signed [ftw_pkg::COARSE_CORR_W-1:0] exp_coarse;
   logic signed [ftw_pkg::FINE_CORR_W-1:0] exp_fine;

   assign exp_coarse = ftw_pkg::COARSE_CORR_W'($signed(COARSE_COUNT)) *
                       ftw_pkg::COARSE_CORR_W'(ftw_pkg::COARSE_STEP_MV);
   assign exp_fine = ftw_pkg::FINE_CORR_W'($signed(FINE_COUNT)) *
                     ftw_pkg::FINE_CORR_W'(ftw_pkg::FINE_STEP_UV);

   a_thermal_fields:
   assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      I_REQ.rd && I_REQ.addr == ftw_pkg::THERMAL_AMP_ADDR |=>
      O_RSP.valid && O_RSP.data[ftw_pkg::OVT_MSB:ftw_pkg::OVT_LSB] ==
      OVT_TRIM)
      else $error("threshold trim field wrong");

   a_amp_field:
   assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      I_REQ.rd && I_REQ.addr == ftw_pkg::THERMAL_AMP_ADDR |=>
      O_RSP.data[ftw_pkg::AMP_MSB:ftw_pkg::AMP_LSB] == AMP_TRIM)
      else $error("amp offset trim field wrong");

   a_thermal_unused:
   assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      I_REQ.rd && I_REQ.addr == ftw_pkg::THERMAL_AMP_ADDR |=>
      O_RSP.data[13:12] == 2'h0 && O_RSP.data[7:4] == 4'h0)
      else $error("unused trim word bits not zero");

   a_temp_ref_word:
   assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      I_REQ.rd && I_REQ.addr == ftw_pkg::TEMP_REF_ADDR |=>
      O_RSP.hit && O_RSP.data[ftw_pkg::TSR_MSB:ftw_pkg::TSR_LSB] == TEMP_REF)
      else $error("temperature reference wrong");

   a_temp_ref_upper:
   assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      I_REQ.rd && I_REQ.addr == ftw_pkg::TEMP_REF_ADDR |=>
      O_RSP.data[13:10] == 4'h0)
      else $error("temperature word upper bits not zero");

   a_coarse_word:
   assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      I_REQ.rd && I_REQ.addr == ftw_pkg::COARSE_OFS_ADDR |=>
      O_RSP.data[ftw_pkg::OFS_MSB:ftw_pkg::OFS_LSB] == COARSE_COUNT)
      else $error("coarse count wrong");

   a_coarse_scale:
   assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      $past(I_RESET_N) |-> O_COARSE_CORR_MV == exp_coarse &&
      O_COARSE_NEG == COARSE_COUNT[ftw_pkg::OFS_MSB])
      else $error("coarse correction wrong");

   a_fine_word:
   assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      I_REQ.rd && I_REQ.addr == ftw_pkg::FINE_OFS_ADDR |=>
      O_RSP.data[ftw_pkg::OFS_MSB:ftw_pkg::OFS_LSB] == FINE_COUNT)
      else $error("fine count wrong");

   a_fine_scale:
   assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      $past(I_RESET_N) |-> O_FINE_CORR_UV == exp_fine &&
      O_FINE_NEG == FINE_COUNT[ftw_pkg::OFS_MSB])
      else $error("fine correction wrong");

   a_offset_upper:
   assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      I_REQ.rd && (I_REQ.addr == ftw_pkg::COARSE_OFS_ADDR ||
      I_REQ.addr == ftw_pkg::FINE_OFS_ADDR) |=> O_RSP.data[13:8] == 6'h00)
      else $error("offset word upper bits not zero");

   a_outside_miss:
   assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      I_REQ.rd && !in_area |=>
      O_RSP.valid && !O_RSP.hit && O_RSP.data == ftw_pkg::ZERO_WORD)
      else $error("read outside area answered as hit");

   a_write_refused:
   assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      I_REQ.wr && in_area && !I_REQ.rd |=>
      O_WR_IGNORED && !O_RSP.valid && $stable(O_RSP.data))
      else $error("write to calibration area had an effect");

   a_read_pulse:
   assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      !I_REQ.rd |=> !O_RSP.valid)
      else $error("answer without a read");

   a_area_hit:
   assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      I_REQ.rd && I_REQ.addr >= ftw_pkg::CAL_FIRST_ADDR &&
      I_REQ.addr <= ftw_pkg::CAL_LAST_ADDR |=> O_RSP.valid && O_RSP.hit)
      else $error("read inside area not answered as hit");

   a_thermal_whole:
   assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      I_REQ.rd && I_REQ.addr == ftw_pkg::THERMAL_AMP_ADDR |=>
      O_RSP.hit && O_RSP.data == {2'h0, OVT_TRIM, 4'h0, AMP_TRIM})
      else $error("thermal and amp trim word wrong");

   a_temp_whole:
   assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      I_REQ.rd && I_REQ.addr == ftw_pkg::TEMP_REF_ADDR |=>
      O_RSP.valid && O_RSP.data == {4'h0, TEMP_REF})
      else $error("temperature reference word wrong");

   a_coarse_whole:
   assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      I_REQ.rd && I_REQ.addr == ftw_pkg::COARSE_OFS_ADDR |=>
      O_RSP.hit && O_RSP.data == {6'h00, COARSE_COUNT})
      else $error("coarse offset word wrong");

   a_fine_whole:
   assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      I_REQ.rd && I_REQ.addr == ftw_pkg::FINE_OFS_ADDR |=>
      O_RSP.hit && O_RSP.data == {6'h00, FINE_COUNT})
      else $error("fine offset word wrong");

   a_answer_holds:
   assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      !I_REQ.rd |=> $stable(O_RSP.data) && $stable(O_RSP.hit))
      else $error("answer changed without a read");

   a_refusal_cause:
   assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      !I_REQ.wr |=> !O_WR_IGNORED)
      else $error("write refusal without a write");

   a_spare_zero:
   assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
      I_REQ.rd && I_REQ.addr >= ftw_pkg::CAL_FIRST_ADDR &&
      I_REQ.addr < ftw_pkg::THERMAL_AMP_ADDR |=>
      O_RSP.data == ftw_pkg::ZERO_WORD)
      else $error("unpopulated area word not zero");

endmodule : ftw_trim_store
`default_nettype wire

// >>> verification/ftw_fw_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// firmware side: copies trim fields into the live trim registers
// ****************************************************************
module ftw_fw_model (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire ftw_pkg::ftw_req_t i_req,
   input wire ftw_pkg::ftw_rsp_t i_rsp,
   output logic [3:0] o_live_threshold_trim_reg,
   output logic [3:0] o_live_amp_offset_trim_reg
);
   logic [13:0] rd_addr;

   // the address of a read is kept until its answer comes back
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rd_addr <= 14'h0000;
         o_live_threshold_trim_reg <= 4'h0;
         o_live_amp_offset_trim_reg <= 4'h0;
      end else begin
         if (i_req.rd) begin
            rd_addr <= i_req.addr;
         end
         if (i_rsp.valid && i_rsp.hit &&
             rd_addr == ftw_pkg::THERMAL_AMP_ADDR) begin
            o_live_threshold_trim_reg <= i_rsp.data[11:8];
            o_live_amp_offset_trim_reg <= i_rsp.data[3:0];
         end
      end
   end
endmodule : ftw_fw_model
`default_nettype wire

// >>> verification/ftw_trim_store_tb.sv
`timescale 1ns/1ns
`default_nettype none
module ftw_trim_store_tb;
   // factory content chosen so that every field differs from erased
   localparam logic [3:0] OVT = 4'ha;
   localparam logic [3:0] AMP = 4'h5;
   localparam logic [9:0] TREF = 10'h2b6;
   localparam logic [7:0] CRS = 8'hfc;
   localparam logic [7:0] FIN = 8'h06;
   // expected corrections follow the weight of one count
   localparam int EXP_CRS = int'(signed'(CRS)) * ftw_pkg::COARSE_STEP_MV;
   localparam int EXP_FIN = int'(signed'(FIN)) * ftw_pkg::FINE_STEP_UV;

   logic clk = 1'b0;
   logic rst_n = 1'b0;
   ftw_pkg::ftw_req_t req = '0;
   ftw_pkg::ftw_rsp_t rsp;
   logic wr_ign, crs_neg, fin_neg;
   logic signed [12:0] crs_corr;
   logic signed [17:0] fin_corr;
   logic [3:0] live_thr, live_amp;
   int error_cnt = 0;
   int compares = 0;
   logic [13:0] a;

   always #50 clk = ~clk;

   ftw_trim_store #(.OVT_TRIM(OVT), .AMP_TRIM(AMP), .TEMP_REF(TREF),
      .COARSE_COUNT(CRS), .FINE_COUNT(FIN)) DUT (
      .I_SYS_CLK(clk),
      .I_RESET_N(rst_n),
      .I_REQ(req),
      .O_RSP(rsp),
      .O_WR_IGNORED(wr_ign),
      .O_COARSE_NEG(crs_neg),
      .O_FINE_NEG(fin_neg),
      .O_COARSE_CORR_MV(crs_corr),
      .O_FINE_CORR_UV(fin_corr)
   );

   ftw_fw_model fw (
      .i_clk(clk),
      .i_rst_n(rst_n),
      .i_req(req),
      .i_rsp(rsp),
      .o_live_threshold_trim_reg(live_thr),
      .o_live_amp_offset_trim_reg(live_amp)
   );

   // ****************************************************************
   // expectations
   // ****************************************************************
   function automatic logic [13:0] exp_word(input logic [13:0] ad);
      case (ad)
         ftw_pkg::THERMAL_AMP_ADDR: return {2'h0, OVT, 4'h0, AMP};
         ftw_pkg::TEMP_REF_ADDR: return {4'h0, TREF};
         ftw_pkg::COARSE_OFS_ADDR: return {6'h00, CRS};
         ftw_pkg::FINE_OFS_ADDR: return {6'h00, FIN};
         default: return 14'h0000;
      endcase
   endfunction : exp_word

   function automatic logic in_area(input logic [13:0] ad);
      return ad >= ftw_pkg::CAL_FIRST_ADDR && ad <= ftw_pkg::CAL_LAST_ADDR;
   endfunction : in_area

   // ****************************************************************
   // checks and transfers
   // ****************************************************************
   task automatic chk(input logic signed [31:0] got,
                      input logic signed [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // request stands from just after one edge to just after the next
   task automatic xfer(input logic rd, input logic wr,
                       input logic [13:0] ad, input logic [13:0] wd);
      req.rd = rd;
      req.wr = wr;
      req.addr = ad;
      req.wdata = wd;
      @(posedge clk);
      #1;
   endtask : xfer

   task automatic rd_chk(input logic [13:0] ad);
      xfer(1'b1, 1'b0, ad, 14'h0000);
      chk(rsp.valid, 1, "valid");
      chk(rsp.hit, in_area(ad), "hit");
      chk(rsp.data, exp_word(ad), "data");
   endtask : rd_chk

   task automatic summarize();
      if (error_cnt == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : summarize

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      void'($urandom(32'h759e3e7e));
      repeat (20) @(posedge clk);
      #1;
      rst_n = 1'b1;
      // the four populated words back to back
      for (int i = 3; i <= 6; i++) begin
         a = ftw_pkg::CAL_FIRST_ADDR + 14'(i);
         rd_chk(a);
      end
      xfer(1'b0, 1'b0, 14'h0000, 14'h0000);
      chk(rsp.valid, 0, "valid pulse");
      chk(rsp.data, exp_word(ftw_pkg::FINE_OFS_ADDR), "data held");
      chk(live_thr, OVT, "live threshold");
      chk(live_amp, AMP, "live amp offset");
      chk(crs_corr, EXP_CRS, "coarse");
      chk(crs_neg, CRS[7], "coarse sign");
      chk(fin_corr, EXP_FIN, "fine");
      chk(fin_neg, FIN[7], "fine sign");
      // whole area, including the words held elsewhere
      for (int i = 0; i < 16; i++) begin
         rd_chk(ftw_pkg::CAL_FIRST_ADDR + 14'(i));
      end
      // random writes into the area, some with a read on the same edge
      for (int i = 0; i < 40; i++) begin
         a = ftw_pkg::CAL_FIRST_ADDR + 14'($urandom_range(15));
         xfer(i[0], 1'b1, a, 14'($urandom));
         chk(wr_ign, 1, "write refused");
         if (i[0]) begin
            chk(rsp.data, exp_word(a), "read beside write");
         end
         xfer(1'b0, 1'b0, a, 14'h0000);
         chk(wr_ign, 0, "refusal pulse");
      end
      // content unchanged after all those writes
      for (int i = 0; i < 16; i++) begin
         rd_chk(ftw_pkg::CAL_FIRST_ADDR + 14'(i));
      end
      // random traffic outside the area
      for (int i = 0; i < 60; i++) begin
         a = 14'($urandom);
         if (in_area(a)) begin
            a = a ^ 14'h1000;
         end
         xfer(1'b0, 1'b1, a, 14'($urandom));
         chk(wr_ign, 0, "write outside");
         rd_chk(a);
      end
      // corner addresses just outside both ends
      rd_chk(ftw_pkg::CAL_FIRST_ADDR - 14'h0001);
      rd_chk(ftw_pkg::CAL_LAST_ADDR + 14'h0001);
      // reset in mid-run: outputs clear at once, corrections return first
      req = '0;
      rst_n = 1'b0;
      @(posedge clk);
      #1;
      chk(rsp, 0, "response in reset");
      chk(wr_ign, 0, "refusal in reset");
      chk(crs_neg, 0, "coarse sign in reset");
      chk(fin_corr, 0, "fine in reset");
      chk(live_thr, 0, "live threshold in reset");
      rst_n = 1'b1;
      @(posedge clk);
      #1;
      chk(crs_corr, EXP_CRS, "coarse after reset");
      chk(fin_corr, EXP_FIN, "fine after reset");
      chk(rsp, 0, "no answer before a read");
      rd_chk(ftw_pkg::THERMAL_AMP_ADDR);
      xfer(1'b0, 1'b0, 14'h0000, 14'h0000);
      chk(live_thr, OVT, "live threshold again");
      chk(live_amp, AMP, "live amp offset again");
      summarize();
   end
endmodule : ftw_trim_store_tb
`default_nettype wire
